// ===== verilog/spmc_top.sv
// per-port activity LED, clear-to-send tracking and nine-bit framing control for six serial ports
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "spmc_regs.svh"

module spmc_top (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// register port
	input wire logic [`SPMC_AW-1:0] addr_i,
	input wire logic [`SPMC_DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [`SPMC_DW-1:0] rdata_o,
	// serial port side
	input wire logic [`SPMC_NPORTS-1:0] port_active_i,
	input wire logic [`SPMC_NPORTS-1:0] cts_i,
	output logic [`SPMC_NPORTS-1:0] led_o,
	output logic [`SPMC_NPORTS-1:0] ch255_o,
	output logic [`SPMC_NPORTS-1:0] cts_evt_o,
	output spmc_pkg::spmc_frames_t frame_o,
	// interrupt
	output logic irq_o
);

	import spmc_pkg::*;

	localparam int NP = `SPMC_NPORTS;

	spmc_state_t st;
	spmc_state_t next_st;
	spmc_req_t req;
	logic [NP-1:0] cts_s;

	// bus signals travel together
	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	// clear-to-send pins come from outside the clock domain
	spmc_sync #(
		.WIDTH(NP)
	) u_cts_sync (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.async_i(cts_i),
		.level_o(cts_s)
	);

	// one-hot port mask from a port number; numbers outside 1..6 select nothing
	function automatic logic [NP-1:0] port_mask(input logic [`SPMC_CMD_PORT_W-1:0] num);
		logic [NP-1:0] m;
		m = '0;
		if (num >= `SPMC_PORT_FIRST && num <= `SPMC_PORT_LAST) begin
			m[num - `SPMC_PORT_FIRST] = 1'b1;
		end
		return m;
	endfunction

	// frame register decode: hit flag and port index, used by both write and read paths
	function automatic logic [3:0] frame_hit(input logic [`SPMC_AW-1:0] a);
		logic [3:0] r;
		r = '0;
		for (int p = 0; p < NP; p++) begin
			if (a == `SPMC_A_FRAME0 + `SPMC_AW'(p) * `SPMC_A_FRAME_STEP) begin
				r = {1'b1, 3'(p)};
			end
		end
		return r;
	endfunction

	// effective framing: the programmed one, or the forced nine-bit one with the baud kept
	function automatic spmc_frame_t eff_frame(input spmc_frame_t prog, input logic nine);
		spmc_frame_t f;
		f = prog;
		if (nine) begin
			f.data_bits = `SPMC_NINE_DATA;
			f.stop_bits = `SPMC_NINE_STOP;
			f.parity = `SPMC_NINE_PAR;
		end
		return f;
	endfunction

	// command decode of the current write
	logic cmd_wr;
	logic [`SPMC_CMD_OP_W-1:0] cmd_op;
	logic [`SPMC_CMD_PORT_W-1:0] cmd_port;
	logic [NP-1:0] cmd_sel;
	logic [NP-1:0] led_sel;

	assign cmd_wr = req.wr && (req.addr == `SPMC_A_CMD);
	assign cmd_op = req.wdata[`SPMC_CMD_OP_LSB +: `SPMC_CMD_OP_W];
	assign cmd_port = req.wdata[`SPMC_CMD_PORT_LSB +: `SPMC_CMD_PORT_W];
	assign cmd_sel = port_mask(cmd_port);
	// LED commands aimed at port 1 reach the whole controller
	assign led_sel = (cmd_port == `SPMC_PORT_FIRST) ? {NP{1'b1}} : cmd_sel;

	// next state: commands, frame writes, tracking, LEDs, interrupt and read data
	always_comb begin
		logic [3:0] fw;
		logic [3:0] fr;
		logic [NP-1:0] evt;
		fw = frame_hit(req.addr);
		fr = frame_hit(req.addr);
		evt = '0;
		next_st = st;

		// mode commands
		if (cmd_wr) begin
			case (cmd_op)
				`SPMC_OP_ACTIVITY_LED_DISABLE: begin
					next_st.activity_led_enable = st.activity_led_enable & ~led_sel;
				end
				`SPMC_OP_ACTIVITY_LED_ENABLE: begin
					next_st.activity_led_enable = st.activity_led_enable | led_sel;
				end
				`SPMC_OP_CTS_ON: begin
					next_st.cts_track = st.cts_track | cmd_sel;
				end
				`SPMC_OP_CTS_OFF: begin
					next_st.cts_track = st.cts_track & ~cmd_sel;
				end
				`SPMC_OP_NINE_ON: begin
					next_st.nine_bit = st.nine_bit | cmd_sel;
				end
				`SPMC_OP_NINE_OFF: begin
					next_st.nine_bit = st.nine_bit & ~cmd_sel;
				end
				default: begin
					next_st.activity_led_enable = st.activity_led_enable;
				end
			endcase
		end

		// programmed framing is always stored so that it can be restored later;
		// the baud divisor is frozen while the port is in nine-bit mode
		if (req.wr && fw[3]) begin
			next_st.prog[fw[2:0]].data_bits = req.wdata[`SPMC_FR_DATA_LSB +: 4];
			next_st.prog[fw[2:0]].stop_bits = req.wdata[`SPMC_FR_STOP_LSB +: 2];
			next_st.prog[fw[2:0]].parity = req.wdata[`SPMC_FR_PAR_LSB +: 2];
			if (!st.nine_bit[fw[2:0]]) begin
				next_st.prog[fw[2:0]].baud_div = req.wdata[`SPMC_FR_BAUD_LSB +: 16];
			end
		end

		// effective framing per port, registered so the outputs come from flip-flops
		for (int p = 0; p < NP; p++) begin
			next_st.frame_out[p] = eff_frame(st.prog[p], st.nine_bit[p]);
		end

		// channel 255 and its push/release events, only for tracked ports
		evt = st.cts_track & (cts_s ^ st.cts_prev);
		next_st.cts_prev = cts_s;
		next_st.ch255 = st.cts_track & cts_s;
		next_st.cts_evt = evt;

		// activity LEDs gated by the enable bits
		next_st.led = st.activity_led_enable & port_active_i;

		// sticky status: a new event wins over a write-one-to-clear in the same cycle
		if (req.wr && req.addr == `SPMC_A_STATUS) begin
			next_st.status = (st.status & ~req.wdata[NP-1:0]) | evt;
		end else begin
			next_st.status = st.status | evt;
		end
		if (req.wr && req.addr == `SPMC_A_MASK) begin
			next_st.mask = req.wdata[NP-1:0];
		end
		// irq follows the registered status, so it lags a new event by one cycle
		next_st.irq = |(st.status & st.mask);

		// read data stands only in the cycle after the read strobe
		next_st.rdata = '0;
		if (req.rd) begin
			if (fr[3]) begin
				next_st.rdata[`SPMC_FR_DATA_LSB +: 4] = st.prog[fr[2:0]].data_bits;
				next_st.rdata[`SPMC_FR_STOP_LSB +: 2] = st.prog[fr[2:0]].stop_bits;
				next_st.rdata[`SPMC_FR_PAR_LSB +: 2] = st.prog[fr[2:0]].parity;
				next_st.rdata[`SPMC_FR_BAUD_LSB +: 16] = st.prog[fr[2:0]].baud_div;
			end else begin
				case (req.addr)
					`SPMC_A_MODE: begin
						next_st.rdata[`SPMC_MODE_LED_LSB +: NP] = st.activity_led_enable;
						next_st.rdata[`SPMC_MODE_CTS_LSB +: NP] = st.cts_track;
						next_st.rdata[`SPMC_MODE_NINE_LSB +: NP] = st.nine_bit;
					end
					`SPMC_A_STATUS: begin
						next_st.rdata[NP-1:0] = st.status;
					end
					`SPMC_A_MASK: begin
						next_st.rdata[NP-1:0] = st.mask;
					end
					`SPMC_A_CHAN: begin
						next_st.rdata[NP-1:0] = st.ch255;
						next_st.rdata[`SPMC_CHAN_RAW_LSB +: NP] = cts_s;
					end
					default: begin
						next_st.rdata = '0;
					end
				endcase
			end
		end
	end

	// state register with synchronous reset to the documented defaults
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			st <= '0;
			st.activity_led_enable <= `SPMC_RST_ACTIVITY_LED_ENABLE;
			for (int p = 0; p < NP; p++) begin
				st.prog[p] <= '{`SPMC_RST_DATA, `SPMC_RST_STOP, `SPMC_RST_PAR, `SPMC_RST_BAUD};
				st.frame_out[p] <= '{`SPMC_RST_DATA, `SPMC_RST_STOP, `SPMC_RST_PAR, `SPMC_RST_BAUD};
			end
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign rdata_o = st.rdata;
	assign led_o = st.led;
	assign ch255_o = st.ch255;
	assign cts_evt_o = st.cts_evt;
	assign frame_o = st.frame_out;
	assign irq_o = st.irq;

	// checks on the behaviour above
	default clocking cb @(posedge sys_clk_i); endclocking

	// helper: previous-cycle values for several checks
	logic past_ok;
	always_ff @(posedge sys_clk_i) begin
		past_ok <= reset_n_i;
	end

	property p_led_dark;
		disable iff (!reset_n_i)
		past_ok |-> (st.led & ~$past(st.activity_led_enable)) == '0;
	endproperty
	a_led_dark: assert property (p_led_dark) else $error("disabled port LED lit");

	property p_led_follow;
		disable iff (!reset_n_i)
		past_ok |-> st.led == ($past(st.activity_led_enable) & $past(port_active_i));
	endproperty
	a_led_follow: assert property (p_led_follow) else $error("enabled LED does not follow activity");

	property p_reset_default;
		!reset_n_i |=> (st.activity_led_enable == `SPMC_RST_ACTIVITY_LED_ENABLE) && (st.nine_bit == '0) && (st.cts_track == '0);
	endproperty
	a_reset_default: assert property (p_reset_default) else $error("wrong mode defaults after reset");

	sequence s_activity_led_disable_port1;
		cmd_wr && cmd_op == `SPMC_OP_ACTIVITY_LED_DISABLE && cmd_port == `SPMC_PORT_FIRST;
	endsequence
	property p_port1_all;
		disable iff (!reset_n_i)
		s_activity_led_disable_port1 |=> st.activity_led_enable == '0 ##1 st.led == '0;
	endproperty
	a_port1_all: assert property (p_port1_all) else $error("port 1 LED command did not reach all ports");

	property p_bad_port;
		disable iff (!reset_n_i)
		(cmd_wr && cmd_op != `SPMC_OP_ACTIVITY_LED_DISABLE && cmd_op != `SPMC_OP_ACTIVITY_LED_ENABLE && cmd_sel == '0)
			|=> $stable(st.cts_track) && $stable(st.nine_bit);
	endproperty
	a_bad_port: assert property (p_bad_port) else $error("command to a port outside 1..6 changed a mode");

	property p_ch255_follow;
		disable iff (!reset_n_i)
		past_ok |-> st.ch255 == ($past(st.cts_track) & $past(cts_s));
	endproperty
	a_ch255_follow: assert property (p_ch255_follow) else $error("channel 255 does not follow clear-to-send");

	property p_cts_evt;
		disable iff (!reset_n_i)
		past_ok |-> st.cts_evt == ($past(st.cts_track) & ($past(cts_s) ^ $past(st.cts_prev)));
	endproperty
	a_cts_evt: assert property (p_cts_evt) else $error("clear-to-send change event wrong");

	property p_untracked_quiet;
		disable iff (!reset_n_i)
		past_ok |-> ((st.ch255 | st.cts_evt) & ~$past(st.cts_track)) == '0;
	endproperty
	a_untracked_quiet: assert property (p_untracked_quiet) else $error("untracked port reports channel 255");

	// an event is already in status in the cycle it is reported, so a clear there cannot hide it
	property p_status_keep;
		disable iff (!reset_n_i)
		(|st.cts_evt) |-> (st.status & st.cts_evt) == st.cts_evt ##1 st.irq == |($past(st.status) & $past(st.mask));
	endproperty
	a_status_keep: assert property (p_status_keep) else $error("event lost from status or interrupt wrong");

	// a write of one clears a status bit unless a new event sets it again in the same cycle
	property p_status_clear;
		disable iff (!reset_n_i)
		(req.wr && req.addr == `SPMC_A_STATUS) |=> (st.status & $past(req.wdata[NP-1:0]) & ~st.cts_evt) == '0;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status bit not cleared by a write of one");

	// read data stand for one cycle only, so software never sees a stale word
	property p_rdata_idle;
		disable iff (!reset_n_i)
		!req.rd |=> st.rdata == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data present without a read");

	// the interrupt is a level that follows the unmasked status one cycle later
	property p_irq_level;
		disable iff (!reset_n_i)
		past_ok |-> st.irq == |($past(st.status) & $past(st.mask));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level does not match status and mask");

	// an LED command to ports 2..6 leaves every other port alone
	sequence s_led_one_port;
		cmd_wr && (cmd_op == `SPMC_OP_ACTIVITY_LED_DISABLE || cmd_op == `SPMC_OP_ACTIVITY_LED_ENABLE) && cmd_port != `SPMC_PORT_FIRST;
	endsequence
	property p_led_one_port;
		disable iff (!reset_n_i)
		s_led_one_port |=> (st.activity_led_enable & ~$past(cmd_sel)) == ($past(st.activity_led_enable) & ~$past(cmd_sel));
	endproperty
	a_led_one_port: assert property (p_led_one_port) else $error("LED command reached other ports");

	// per-port framing checks
	for (genvar g = 0; g < NP; g++) begin : g_frame_chk
		sequence s_nine_on;
			cmd_wr && cmd_op == `SPMC_OP_NINE_ON && cmd_sel[g];
		endsequence
		sequence s_nine_off;
			cmd_wr && cmd_op == `SPMC_OP_NINE_OFF && cmd_sel[g] && !(req.wr && frame_hit(req.addr) == {1'b1, 3'(g)});
		endsequence
		property p_nine_on;
			disable iff (!reset_n_i)
			s_nine_on |=> ##1 st.frame_out[g].data_bits == `SPMC_NINE_DATA
				&& st.frame_out[g].stop_bits == `SPMC_NINE_STOP && st.frame_out[g].parity == `SPMC_NINE_PAR;
		endproperty
		a_nine_on: assert property (p_nine_on) else $error("nine-bit framing not forced");
		property p_baud_lock;
			disable iff (!reset_n_i)
			st.nine_bit[g] |=> $stable(st.prog[g].baud_div);
		endproperty
		a_baud_lock: assert property (p_baud_lock) else $error("baud changed in nine-bit mode");
		property p_nine_off;
			disable iff (!reset_n_i)
			s_nine_off |=> ##1 st.frame_out[g] == $past(st.prog[g]);
		endproperty
		a_nine_off: assert property (p_nine_off) else $error("programmed framing not restored");
	end

endmodule

`default_nettype wire

// ===== verilog/spmc_regs.svh
// register offsets, field positions, command codes and reset values of the serial port mode block
`ifndef SPMC_REGS_SVH
`define SPMC_REGS_SVH

`define SPMC_NPORTS 6
`define SPMC_AW 8
`define SPMC_DW 32

// byte addresses
`define SPMC_A_CMD 8'h00
`define SPMC_A_MODE 8'h04
`define SPMC_A_STATUS 8'h08
`define SPMC_A_MASK 8'h0c
`define SPMC_A_CHAN 8'h10
`define SPMC_A_FRAME0 8'h14
`define SPMC_A_FRAME_STEP 8'h04

// command register fields
`define SPMC_CMD_PORT_LSB 0
`define SPMC_CMD_PORT_W 3
`define SPMC_CMD_OP_LSB 4
`define SPMC_CMD_OP_W 3
`define SPMC_OP_ACTIVITY_LED_DISABLE 3'h1
`define SPMC_OP_ACTIVITY_LED_ENABLE 3'h2
`define SPMC_OP_CTS_ON 3'h3
`define SPMC_OP_CTS_OFF 3'h4
`define SPMC_OP_NINE_ON 3'h5
`define SPMC_OP_NINE_OFF 3'h6
`define SPMC_PORT_FIRST 3'h1
`define SPMC_PORT_LAST 3'h6

// mode and channel register field positions
`define SPMC_MODE_LED_LSB 0
`define SPMC_MODE_CTS_LSB 8
`define SPMC_MODE_NINE_LSB 16
`define SPMC_CHAN_RAW_LSB 8

// frame register fields
`define SPMC_FR_DATA_LSB 0
`define SPMC_FR_STOP_LSB 4
`define SPMC_FR_PAR_LSB 6
`define SPMC_FR_BAUD_LSB 8

// reset values and the forced nine-bit framing
`define SPMC_RST_ACTIVITY_LED_ENABLE 6'h3f
`define SPMC_RST_DATA 4'h8
`define SPMC_RST_STOP 2'h1
`define SPMC_RST_PAR 2'h0
`define SPMC_RST_BAUD 16'h0060
`define SPMC_NINE_DATA 4'h9
`define SPMC_NINE_STOP 2'h1
`define SPMC_NINE_PAR 2'h0

`endif

// ===== verilog/spmc_pkg.sv
// types shared by the serial port mode block
`default_nettype none
`include "spmc_regs.svh"

package spmc_pkg;

	// framing of one port: data bits, stop bits, parity code, baud divisor
	typedef struct packed {
		logic [3:0] data_bits;
		logic [1:0] stop_bits;
		logic [1:0] parity;
		logic [15:0] baud_div;
	} spmc_frame_t;

	typedef spmc_frame_t [`SPMC_NPORTS-1:0] spmc_frames_t;

	// register bus request
	typedef struct packed {
		logic [`SPMC_AW-1:0] addr;
		logic [`SPMC_DW-1:0] wdata;
		logic wr;
		logic rd;
	} spmc_req_t;

	// whole state of the top module
	typedef struct packed {
		logic [`SPMC_NPORTS-1:0] activity_led_enable;
		logic [`SPMC_NPORTS-1:0] cts_track;
		logic [`SPMC_NPORTS-1:0] nine_bit;
		spmc_frames_t prog;
		spmc_frames_t frame_out;
		logic [`SPMC_NPORTS-1:0] cts_prev;
		logic [`SPMC_NPORTS-1:0] ch255;
		logic [`SPMC_NPORTS-1:0] cts_evt;
		logic [`SPMC_NPORTS-1:0] led;
		logic [`SPMC_NPORTS-1:0] status;
		logic [`SPMC_NPORTS-1:0] mask;
		logic irq;
		logic [`SPMC_DW-1:0] rdata;
	} spmc_state_t;

endpackage

`default_nettype wire

// ===== verilog/spmc_sync.sv
// three-stage synchroniser that accepts a new level once the last two stages agree
`timescale 1ns/1ps
`default_nettype none

module spmc_sync #(
	parameter int WIDTH = 6
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// asynchronous levels in, settled levels out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] level_o
);

	typedef struct packed {
		logic [WIDTH-1:0] ff1;
		logic [WIDTH-1:0] ff2;
		logic [WIDTH-1:0] ff3;
		logic [WIDTH-1:0] level;
	} spmc_sync_st_t;

	spmc_sync_st_t st;
	spmc_sync_st_t next_st;

	// ff1 feeds only ff2; the agreement test looks at ff2 and ff3
	always_comb begin
		next_st = st;
		next_st.ff1 = async_i;
		next_st.ff2 = st.ff1;
		next_st.ff3 = st.ff2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st.ff2[i] == st.ff3[i]) begin
				next_st.level[i] = st.ff3[i];
			end
		end
	end

	// synchronous reset to all low
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level_o = st.level;

endmodule

`default_nettype wire

// ===== test/spmc_serial_model.sv
// behavioural serial equipment on the far side: port activity and clear-to-send levels
`timescale 1ns/1ps
`default_nettype none
`include "spmc_regs.svh"

module spmc_serial_model (
	// clock
	input wire logic sys_clk_i,
	// levels the bench asks for
	input wire logic [`SPMC_NPORTS-1:0] want_cts_i,
	input wire logic [`SPMC_NPORTS-1:0] want_act_i,
	// lines towards the block
	output logic [`SPMC_NPORTS-1:0] cts_o,
	output logic [`SPMC_NPORTS-1:0] active_o
);
	// clear-to-send is unrelated to our clock, so it lands off the edge to exercise the synchroniser
	initial begin
		cts_o = '0;
		forever begin
			@(want_cts_i);
			cts_o <= #1.7 want_cts_i;
		end
	end

	// activity comes from logic in the same clock domain; one process per line keeps a single driver
	initial begin
		active_o = '0;
		forever begin
			@(posedge sys_clk_i);
			active_o <= want_act_i;
		end
	end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the serial port mode block
`timescale 1ns/1ps
`default_nettype none
`include "spmc_regs.svh"

module tb_top;
	import spmc_pkg::*;
	logic sys_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [`SPMC_AW-1:0] addr_i = 8'h00;
	logic [`SPMC_DW-1:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [`SPMC_DW-1:0] rdata_o;
	logic [`SPMC_NPORTS-1:0] port_active_i, cts_i, led_o, ch255_o, cts_evt_o;
	logic [`SPMC_NPORTS-1:0] want_cts = 6'h00;
	logic [`SPMC_NPORTS-1:0] want_act = 6'h00;
	logic irq_o;
	spmc_frames_t frame_o;
	int err_total = 0;
	int cmp_count = 0;
	int evt_seen = 0;

	// 200 MHz clock
	initial begin
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	spmc_top spmc_top_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port_active_i(port_active_i), .cts_i(cts_i),
		.led_o(led_o), .ch255_o(ch255_o), .cts_evt_o(cts_evt_o), .frame_o(frame_o), .irq_o(irq_o));

	spmc_serial_model spmc_serial_model_i (.sys_clk_i(sys_clk_i), .want_cts_i(want_cts),
		.want_act_i(want_act), .cts_o(cts_i), .active_o(port_active_i));

	// event pulses last one cycle, so they are counted rather than sampled
	always @(posedge sys_clk_i) begin
		if ((|cts_evt_o) === 1'b1)
			evt_seen <= evt_seen + 1;
	end

	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// wait n edges, then step past the edge so registered outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1;
		check(what, rdata_o, exp);
	endtask

	task automatic cmd(input logic [2:0] port, input logic [2:0] op);
		wr(`SPMC_A_CMD, {25'h0, op, 1'b0, port});
	endtask

	task automatic fr(input int p, input logic [23:0] exp);
		check("frame out", {8'h00, frame_o[p-1]}, {8'h00, exp});
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// watchdog: the tests take well under a thousand cycles
	initial begin
		#20000;
		err_total++;
		$display("unexpected at %0t: watchdog expired", $time);
		summarize();
	end

	initial begin
		repeat (16) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		// reset defaults and an unmapped read
		rd(`SPMC_A_MODE, 32'h0000003f, "mode after reset");
		rd(`SPMC_A_FRAME0, 32'h00006018, "frame reg after reset");
		fr(1, {4'h8, 2'h1, 2'h0, 16'h0060});
		rd(8'h40, 32'h0, "unmapped read");
		want_act <= 6'h3f;
		cyc(3);
		check("led default on", {26'h0, led_o}, 32'h3f);
		want_act <= 6'h15;
		cyc(3);
		check("led follows activity", {26'h0, led_o}, 32'h15);
		$display("test reset done");
		// port 1 LED commands act on every port, others on their own
		want_act <= 6'h3f;
		cmd(1, `SPMC_OP_ACTIVITY_LED_DISABLE);
		cyc(3);
		check("led dark", {26'h0, led_o}, 32'h0);
		rd(`SPMC_A_MODE, 32'h0, "mode all off");
		cmd(1, `SPMC_OP_ACTIVITY_LED_ENABLE);
		cyc(3);
		check("led all on", {26'h0, led_o}, 32'h3f);
		cmd(3, `SPMC_OP_ACTIVITY_LED_DISABLE);
		cmd(7, `SPMC_OP_ACTIVITY_LED_DISABLE);
		cyc(3);
		check("led port 3 off", {26'h0, led_o}, 32'h3b);
		cmd(1, `SPMC_OP_ACTIVITY_LED_ENABLE);
		$display("test led done");
		// clear-to-send ignored until tracking is on
		want_cts <= 6'h02;
		cyc(8);
		check("ch255 untracked", {26'h0, ch255_o}, 32'h0);
		check("no events untracked", evt_seen, 32'h0);
		rd(`SPMC_A_CHAN, 32'h00000200, "chan raw cts");
		cmd(2, `SPMC_OP_CTS_ON);
		cyc(4);
		check("ch255 tracked high", {26'h0, ch255_o}, 32'h02);
		want_cts <= 6'h00;
		cyc(8);
		check("ch255 tracked low", {26'h0, ch255_o}, 32'h0);
		check("release event", evt_seen, 32'h1);
		rd(`SPMC_A_STATUS, 32'h02, "status sticky");
		check("irq masked", {31'h0, irq_o}, 32'h0);
		wr(`SPMC_A_MASK, 32'h02);
		cyc(3);
		check("irq unmasked", {31'h0, irq_o}, 32'h1);
		wr(`SPMC_A_STATUS, 32'h02);
		cyc(3);
		check("irq cleared", {31'h0, irq_o}, 32'h0);
		want_cts <= 6'h02;
		cyc(8);
		check("push event", evt_seen, 32'h2);
		check("ch255 high again", {26'h0, ch255_o}, 32'h02);
		cmd(2, `SPMC_OP_CTS_OFF);
		cyc(3);
		check("ch255 off", {26'h0, ch255_o}, 32'h0);
		want_cts <= 6'h00;
		cyc(8);
		check("no event after off", evt_seen, 32'h2);
		$display("test cts done");
		// nine-bit framing forces the frame and freezes the baud divisor
		wr(`SPMC_A_FRAME0 + 8'h0c, 32'h001234a7);
		cyc(3);
		fr(4, {4'h7, 2'h2, 2'h2, 16'h1234});
		cmd(4, `SPMC_OP_NINE_ON);
		cyc(3);
		fr(4, {4'h9, 2'h1, 2'h0, 16'h1234});
		wr(`SPMC_A_FRAME0 + 8'h0c, 32'h005555a6);
		cyc(3);
		fr(4, {4'h9, 2'h1, 2'h0, 16'h1234});
		cmd(4, `SPMC_OP_NINE_OFF);
		cyc(3);
		fr(4, {4'h6, 2'h2, 2'h2, 16'h1234});
		cmd(7, `SPMC_OP_NINE_ON);
		cmd(0, `SPMC_OP_CTS_ON);
		cmd(2, 3'h7);
		rd(`SPMC_A_MODE, 32'h0000003f, "bad port or opcode ignored");
		for (int p = 1; p <= 6; p++)
			cmd(3'(p), `SPMC_OP_NINE_ON);
		rd(`SPMC_A_MODE, 32'h003f003f, "mode nine on all");
		cyc(3);
		for (int p = 1; p <= 6; p++)
			fr(p, {4'h9, 2'h1, 2'h0, (p == 4) ? 16'h1234 : 16'h0060});
		$display("test nine-bit done");
		summarize();
	end
endmodule
`default_nettype wire
